// file: rtl/i2cra_cfg.svh
`ifndef I2CRA_CFG_SVH
`define I2CRA_CFG_SVH
// Target address, byte framing and reset values
`define I2CRA_DEV_ADDR   7'h7E
`define I2CRA_BYTE_BITS  4'h8
`define I2CRA_PTR_RST    8'h00
`define I2CRA_DATA_RST   8'h00
`endif

// file: rtl/i2cra_pkg.sv
package i2cra_pkg;
  // Protocol phases of the target
  typedef enum logic [2:0] {
    I2CRA_IDLE,
    I2CRA_ADDR,
    I2CRA_PTR,
    I2CRA_WDATA,
    I2CRA_RDATA,
    I2CRA_IGNORE
  } i2cra_state_e;

  // Register write strobe with its address and data
  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } i2cra_wr_s;
endpackage

// file: rtl/i2cra_target.sv
`timescale 1ns/1ps
`include "i2cra_cfg.svh"
// Functional notes
// R1: Sample data on clock high, shift while low
// R2: Data change mid-transaction with clock high aborts
// R3: Bytes are eight bits, MSB first, acked
// R4: Start is SDA fall, stop rise, SCL high
// R5: Only master makes start and stop
// R6: Repeated start accepted, switches to reading
// R7: Ninth clock acknowledge, receiver holds SDA low
// R8: Master nacks final read byte
// R9: Respond and acknowledge only address 1111110
// R10: Seven address bits then direction bit
// R11: Write: pointer byte then data, both acked
// R12: Pointer advances by one per written byte
// R13: Master ends write with stop
// R14: Read uses pointer write then repeated start
// R15: Master ack advances pointer, next byte sent
// R16: Master ends read with nack and stop
// R17: Address mismatch: stay released until start
module i2cra_target
  import i2cra_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Register file access
  output i2cra_wr_s       reg_wr,
  output logic [7:0]      reg_rd_addr,
  input  wire logic [7:0] reg_rd_data,
  // Status
  output logic            busy
);

  logic [1:0]   scl_sync_r;
  logic [1:0]   sda_sync_r;
  logic         scl_d_r;
  logic         sda_d_r;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  i2cra_state_e state_r;
  logic [3:0]   bit_cnt_r;
  logic [7:0]   shift_r;
  logic [7:0]   ptr_r;
  logic         ack_phase_r;
  logic         drive_low_r;
  logic         tx_bit;
  logic         active;
  logic         byte_end;
  logic         ack_end;
  logic         sda_out_r;
  logic         tx_mode_r;
  logic         master_nack_r;
  logic         busy_r;
  i2cra_wr_s    wr_r;
  logic [7:0]   tx_byte_r;

  // Two-flop synchronisers for the pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
    end
  end

  // Delayed copies for edge finding
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  // Edge and condition detection
  assign scl_rise  = scl_sync_r[1] & ~scl_d_r;
  assign scl_fall  = ~scl_sync_r[1] & scl_d_r;
  assign start_det = scl_sync_r[1] & scl_d_r & sda_d_r
                   & ~sda_sync_r[1]; // R4
  assign stop_det  = scl_sync_r[1] & scl_d_r & ~sda_d_r
                   & sda_sync_r[1]; // R4

  // Bus busy from start until stop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1; // R5
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  // Transaction qualifiers shared by the engine blocks
  assign active   = (state_r != I2CRA_IDLE)
                  && (state_r != I2CRA_IGNORE);
  // Falling clock that closes the eighth bit of a byte
  assign byte_end = scl_fall && !ack_phase_r
                  && (bit_cnt_r == `I2CRA_BYTE_BITS); // R3
  // Falling clock that closes the ninth, acknowledge clock
  assign ack_end  = scl_fall && ack_phase_r; // R7

  // Protocol state, bit count and acknowledge phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r     <= I2CRA_IDLE;
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'b0;
      tx_mode_r   <= 1'b0;
    end else if (start_det) begin
      // Start or repeated start restarts address phase
      state_r     <= I2CRA_ADDR; // R6
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'b0;
      tx_mode_r   <= 1'b0;
    end else if (stop_det) begin
      // Stop, or a stop-like glitch, ends the transaction
      state_r     <= I2CRA_IDLE; // R2 R13 R16
      ack_phase_r <= 1'b0;
      tx_mode_r   <= 1'b0;
    end else if (active) begin
      if (scl_rise && !ack_phase_r) begin
        // Count bits of the byte; ack clock is not counted
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (ack_end) begin
        // Ninth clock over, next byte starts from zero
        ack_phase_r <= 1'b0;
        bit_cnt_r   <= 4'h0;
        if (state_r == I2CRA_RDATA && master_nack_r) begin
          state_r <= I2CRA_IGNORE; // R16
        end
      end else if (byte_end) begin
        ack_phase_r <= 1'b1; // R7
        case (state_r)
          I2CRA_ADDR: begin
            if (shift_r[7:1] != `I2CRA_DEV_ADDR) begin
              // Foreign target: no ack slot of ours
              state_r     <= I2CRA_IGNORE; // R17
              ack_phase_r <= 1'b0;
            end else if (shift_r[0]) begin
              state_r   <= I2CRA_RDATA; // R10 R14
              tx_mode_r <= 1'b1;
            end else begin
              state_r <= I2CRA_PTR; // R10
            end
          end
          I2CRA_PTR: begin
            state_r <= I2CRA_WDATA; // R11
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end
    end
  end

  // Receive shift register, MSB arrives first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= `I2CRA_DATA_RST;
    end else if (scl_rise && active && !ack_phase_r) begin
      shift_r <= {shift_r[6:0], sda_sync_r[1]}; // R1 R3
    end
  end

  // Master's answer in the ack slot of a read byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      master_nack_r <= 1'b0;
    end else if (scl_rise && active && ack_phase_r) begin
      master_nack_r <= sda_sync_r[1]; // R8
    end
  end

  // Register pointer: loaded by the pointer byte, then steps
  // The read step happens on the ack clock's rising edge so
  // that the next byte is already addressed when SCL falls.
  // Our own address ack also reads low, but we drive it then.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= `I2CRA_PTR_RST;
    end else if (byte_end && state_r == I2CRA_PTR) begin
      ptr_r <= shift_r; // R11
    end else if (byte_end && state_r == I2CRA_WDATA) begin
      ptr_r <= ptr_r + 8'h01; // R12
    end else if (scl_rise && ack_phase_r && state_r == I2CRA_RDATA
                 && !drive_low_r && !sda_sync_r[1]) begin
      ptr_r <= ptr_r + 8'h01; // R15
    end
  end

  // One-cycle write strobe per received data byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= '0;
    end else if (byte_end && state_r == I2CRA_WDATA) begin
      wr_r.stb  <= 1'b1; // R11
      wr_r.addr <= ptr_r;
      wr_r.data <= shift_r;
    end else begin
      wr_r.stb <= 1'b0;
    end
  end

  // Byte to transmit, latched as the ack clock ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_byte_r <= `I2CRA_DATA_RST;
    end else if (ack_end) begin
      tx_byte_r <= reg_rd_data; // R14 R15
    end
  end

  // Current transmit bit, MSB first
  // Count k bits already sent selects bit 7-k of the byte
  always_comb begin
    if (bit_cnt_r == 4'h0) begin
      tx_bit = reg_rd_data[7];
    end else begin
      tx_bit = tx_byte_r[3'(4'h7 - bit_cnt_r)];
    end
  end

  // Data line drive, updated as the clock falls, and released at start and stop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_low_r <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low_r <= 1'b0;
    end else if (ack_end) begin
      // Leaving ack slot: first read bit, else release
      drive_low_r <= (state_r == I2CRA_RDATA) && !master_nack_r
                     && !reg_rd_data[7]; // R15
    end else if (byte_end) begin
      // Acknowledge a received byte, our address included
      drive_low_r <= !tx_mode_r && active
        && (state_r != I2CRA_ADDR
            || shift_r[7:1] == `I2CRA_DEV_ADDR); // R7 R9 R17
    end else if (scl_fall && state_r == I2CRA_RDATA) begin
      drive_low_r <= !tx_bit; // R1 R3
    end else if (scl_fall) begin
      drive_low_r <= 1'b0;
    end
  end

  // Open-drain data pin only ever pulls low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  // Outputs straight from their flops
  assign sda_out     = sda_out_r;
  assign sda_oe      = drive_low_r;
  assign reg_wr      = wr_r;
  assign reg_rd_addr = ptr_r;
  assign busy        = busy_r;

endmodule // i2cra_target

// file: tb/i2cra_target_sva.sv
`timescale 1ns/1ps
module i2cra_target_sva
  import i2cra_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Register side
  input wire i2cra_wr_s  reg_wr,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  // Status
  input wire logic       busy
);
  logic [7:0] nxt_ptr_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Pointer expected after a stored byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nxt_ptr_r <= 8'h00;
    end else if (reg_wr.stb) begin
      nxt_ptr_r <= reg_wr.addr + 8'h01;
    end
  end
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_start_busy: assert property (scl_in && $fell(sda_in) |-> ##[1:6] busy)
    else $error("start missed");
  a_stop_idle: assert property (scl_in && $rose(sda_in) |-> ##[1:6] !busy)
    else $error("stop missed");
  a_idle_free: assert property (!busy |-> !sda_oe)
    else $error("drive while idle");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved in high");
  a_stb_pulse: assert property (reg_wr.stb |=> !reg_wr.stb)
    else $error("strobe too long");
  a_stb_frame: assert property (reg_wr.stb |-> busy && !scl_in)
    else $error("strobe outside byte");
  a_ptr_step: assert property (reg_wr.stb |=> ##[0:4] reg_rd_addr == nxt_ptr_r)
    else $error("pointer not advanced");
endmodule // i2cra_target_sva

// file: tb/i2cra_master_bfm.sv
`timescale 1ns/1ps
module i2cra_master_bfm (
  // Open-drain bus
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  logic in_frame;
  // Bus idles high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    in_frame = 1'b0;
  end
  // One clock: data set mid-low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    #30 sda_low = !b;
    #30 scl = 1'b1;
    #10 r = sda;
    #10;
  endtask
  // Start, or repeated start inside a frame
  task automatic start();
    if (in_frame) begin
      scl = 1'b0;
      #30 sda_low = 1'b0;
      #30 scl = 1'b1;
      #20;
    end
    sda_low = 1'b1;
    #20 in_frame = 1'b1;
  endtask
  // Stop: data rises with clock high
  task automatic stop();
    scl = 1'b0;
    #30 sda_low = 1'b1;
    #30 scl = 1'b1;
    #20 sda_low = 1'b0;
    #20 in_frame = 1'b0;
  endtask
  // Byte MSB first, then ninth clock
  task automatic xfer(input logic [7:0] d, input logic rel,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(rel, ack);
  endtask
endmodule // i2cra_master_bfm

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import i2cra_pkg::*;
  logic       clk, rstn, scl, m_low, sda_out, sda_oe, busy, ak;
  wire logic  sda;
  i2cra_wr_s  reg_wr;
  logic [7:0] reg_rd_addr, q, p;
  logic [7:0] mem [256];
  logic [7:0] ex [256];
  int         n, error_cnt, cmp_count;
  // Pull-up wins unless someone pulls low
  assign sda = !(m_low | (sda_oe & !sda_out));
  i2cra_master_bfm m (.scl(scl), .sda_low(m_low), .sda(sda));
  i2cra_target uut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_wr(reg_wr), .busy(busy),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(mem[reg_rd_addr]));
  // Register file
  always @(posedge clk) if (reg_wr.stb) mem[reg_wr.addr] <= reg_wr.data;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Address phase with expected ack level
  task automatic adr(input logic [6:0] a, input logic rd, input logic e);
    m.start();
    m.xfer({a, rd}, 1'b1, q, ak);
    chk({7'h0, ak}, {7'h0, e});
  endtask
  task automatic wr(input logic [7:0] pt, input int k);
    adr(7'h7E, 1'b0, 1'b0);
    m.xfer(pt, 1'b1, q, ak);
    chk({7'h0, ak}, 8'h00);
    for (int i = 0; i < k; i++) begin
      ex[pt + i[7:0]] = 8'($urandom);
      m.xfer(ex[pt + i[7:0]], 1'b1, q, ak);
      chk({7'h0, ak}, 8'h00);
    end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] pt, input int k);
    adr(7'h7E, 1'b0, 1'b0);
    m.xfer(pt, 1'b1, q, ak);
    adr(7'h7E, 1'b1, 1'b0);
    for (int i = 0; i < k; i++) begin
      m.xfer(8'hFF, i == k - 1, q, ak);
      chk(q, ex[pt + i[7:0]]);
    end
    m.stop();
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #500_000;
    error_cnt++;
    test_done();
  end
  initial begin
    rstn = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
      ex[i] = 8'h00;
    end
    void'($urandom(32'h467c));
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    wr(8'hFD, 3);
    rd(8'hFD, 3);
    repeat (4) begin
      p = 8'($urandom_range(0, 200));
      n = $urandom_range(1, 4);
      wr(p, n);
      rd(p, n);
    end
    // Foreign address is ignored
    adr(7'h7E ^ 7'($urandom_range(1, 127)), 1'b0, 1'b1);
    m.xfer(8'h10, 1'b1, q, ak);
    chk({7'h0, ak}, 8'h01);
    m.stop();
    // Stop inside a data byte aborts it
    adr(7'h7E, 1'b0, 1'b0);
    m.xfer(8'h10, 1'b1, q, ak);
    repeat (4) m.bit_x(1'b0, ak);
    m.stop();
    repeat (8) @(posedge clk);
    chk({7'h0, busy}, 8'h00);
    rd(8'h10, 1);
    test_done();
  end
endmodule // tb
bind i2cra_target i2cra_target_sva u_sva (.clk(clk), .rstn(rstn),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
  .busy(busy));
